// ===== rtl/bac_pkg.sv
// Package with register map, field positions and timing constants of the accumulator bank
package bac_pkg;
   // Register indices (byte addresses on the plain register port)
   localparam logic [7:0] ADDR_CHARGE_SUM      = 8'h28;
   localparam logic [7:0] ADDR_CHARGE_TIME     = 8'h2c;
   localparam logic [7:0] ADDR_TEMP_SUM        = 8'h30;
   localparam logic [7:0] ADDR_TEMP_TIME       = 8'h34;
   localparam logic [7:0] ADDR_CELL2_SUM       = 8'h38;
   localparam logic [7:0] ADDR_CELL2_TIME      = 8'h3c;
   localparam logic [7:0] ADDR_DISCHARGE_SUM   = 8'h20;
   localparam logic [7:0] ADDR_CONV_CONFIG     = 8'h43;
   localparam logic [7:0] ADDR_SUM_WIPE        = 8'h62;
   localparam logic [7:0] ADDR_ACCUM_SETUP     = 8'h63;
   localparam logic [7:0] ADDR_CONV_STATUS     = 8'h64;
   // Conversion configuration fields
   localparam int         CFG_MASTER_BIT       = 7;
   localparam int         CFG_SAMPLE_BIT       = 6;
   localparam int         CFG_EXP_LSB          = 0;
   localparam int         CFG_EXP_W            = 3;
   localparam logic [7:0] CFG_WRITE_MASK       = 8'hc7;
   localparam logic [7:0] CFG_RESET            = 8'h00;
   // Accumulator setup fields
   localparam int         SET_MASTER_BIT       = 7;
   localparam int         SET_CURR_BIT         = 6;
   localparam int         SET_TEMP_BIT         = 5;
   localparam int         SET_CELL2_BIT        = 4;
   localparam int         SET_TSEL_BIT         = 3;
   localparam logic [7:0] SET_WRITE_MASK       = 8'hf8;
   localparam logic [7:0] SET_RESET            = 8'h00;
   // Wipe register bit positions
   localparam int         WIPE_DISCHARGE_SUM   = 1;
   localparam int         WIPE_CHARGE_SUM      = 2;
   localparam int         WIPE_CHARGE_TIME     = 3;
   localparam int         WIPE_TEMP_SUM        = 4;
   localparam int         WIPE_TEMP_TIME       = 5;
   localparam int         WIPE_CELL2_SUM       = 6;
   localparam int         WIPE_CELL2_TIME      = 7;
   // Nonvolatile layout starts
   localparam logic [8:0] NV_FACTORY_BASE      = 9'h088;
   localparam logic [8:0] NV_CAL_STATUS        = 9'h08c;
   localparam logic [7:0] NV_CAL_STATUS_DFLT   = 8'h00;
   localparam logic [8:0] NV_GAUGE_BASE        = 9'h0a5;
   localparam logic [8:0] NV_VEOD_TABLE        = 9'h0c0;
   // Timing
   localparam int         CLK_HZ               = 125_000_000;
   localparam int         TICK_HZ              = 2;
   localparam int         TICK_CYCLES          = CLK_HZ / TICK_HZ;
   localparam int         RESULT_W             = 16;
   localparam int         ACC_W                = 32;
endpackage

// ===== rtl/bac_event_if.sv
// Interface carrying conversion results and their completion strobes into the bank
`timescale 1ns/1ps
`default_nettype none
interface bac_event_if;
   logic        tick;
   logic        curr_done;
   logic [15:0] curr_result;
   logic        temp_done;
   logic [15:0] temp_result;
   logic        cell2_done;
   logic [15:0] cell2_result;
   modport src (output tick, curr_done, curr_result, temp_done, temp_result, cell2_done, cell2_result);
   modport dst (input  tick, curr_done, curr_result, temp_done, temp_result, cell2_done, cell2_result);
endinterface
`default_nettype wire

// ===== rtl/bac_tick_gen.sv
// Half-second tick divider and sample-period scheduler
`timescale 1ns/1ps
`default_nettype none
module bac_tick_gen #(
   parameter int TICK_CYCLES = bac_pkg::TICK_CYCLES
) (
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   input  wire logic       master_on_i,
   input  wire logic       sample_mode_i,
   input  wire logic [2:0] exponent_i,
   output logic            tick_o,
   output logic            window_o
);
   logic [31:0] div_reg;
   logic [7:0]  period_reg;
   logic [7:0]  period_len;

   assign period_len = 8'h01 << exponent_i;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         div_reg <= 32'h0;
         tick_o  <= 1'b0;
      end else if (div_reg == 32'(TICK_CYCLES - 1)) begin
         div_reg <= 32'h0;
         tick_o  <= 1'b1;
      end else begin
         div_reg <= div_reg + 32'h1;
         tick_o  <= 1'b0;
      end
   end

   // Sample mode opens one window per 0.5 s * 2^exponent; run mode keeps it open
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         period_reg <= 8'h0;
         window_o   <= 1'b0;
      end else if (!master_on_i) begin
         period_reg <= 8'h0;
         window_o   <= 1'b0;
      end else if (!sample_mode_i) begin
         period_reg <= 8'h0;
         window_o   <= 1'b1;
      end else if (tick_o) begin
         if (period_reg + 8'h1 >= period_len) begin
            period_reg <= 8'h0;
            window_o   <= 1'b1;
         end else begin
            period_reg <= period_reg + 8'h1;
            window_o   <= 1'b0;
         end
      end else begin
         window_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== rtl/bac_event_stage.sv
// Registers the converter strobes and results into the event carrier
`timescale 1ns/1ps
`default_nettype none
module bac_event_stage (
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   input  wire logic        tick_i,
   input  wire logic        conv_ok_i,
   input  wire logic        curr_done_i,
   input  wire logic [15:0] curr_result_i,
   input  wire logic        int_temp_done_i,
   input  wire logic [15:0] int_temp_result_i,
   input  wire logic        ext_temp_done_i,
   input  wire logic [15:0] ext_temp_result_i,
   input  wire logic        cell2_done_i,
   input  wire logic [15:0] cell2_result_i,
   input  wire logic        tsel_i,
   bac_event_if.src         ev
);
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ev.tick         <= 1'b0;
         ev.curr_done    <= 1'b0;
         ev.curr_result  <= 16'h0;
         ev.temp_done    <= 1'b0;
         ev.temp_result  <= 16'h0;
         ev.cell2_done   <= 1'b0;
         ev.cell2_result <= 16'h0;
      end else begin
         ev.tick         <= tick_i;
         ev.curr_done    <= curr_done_i && conv_ok_i;
         ev.curr_result  <= curr_result_i;
         ev.temp_done    <= (tsel_i ? ext_temp_done_i : int_temp_done_i) && conv_ok_i;
         ev.temp_result  <= tsel_i ? ext_temp_result_i : int_temp_result_i;
         ev.cell2_done   <= cell2_done_i && conv_ok_i;
         ev.cell2_result <= cell2_result_i;
      end
   end
endmodule
`default_nettype wire

// ===== rtl/bac_bank.sv
// Battery accumulator and elapsed-time counter bank with conversion configuration
//
// Behaviour
// - Charge time counts 2 Hz ticks while current accumulates and last sign positive
// - All sums and counters wrap past maximum; host maintains them
// - Wipe register bits 3 to 7 zero charge time, temp sum/time, cell2 sum/time
// - Temperature sum adds internal or external result chosen by select bit
// - Temperature time counts 2 Hz ticks while temperature accumulation is on
// - Cell-2 sum adds cell-2 result on each completed measurement when enabled
// - Cell-2 time counts 2 Hz ticks while cell-2 measurements are taken
// - Config bit 7 is the master conversion enable; host clears when idle
// - Config bit 6 picks sample mode (1) or continuous run mode (0)
// - Sample interval is 0.5 s times two to the period exponent
// - Config bits 5 to 3 are reserved and read as zero
// - Nonvolatile factory region starts at 0x88, calibration status defaults 0
// - Nonvolatile gauge parameter region starts at 0xA5
// - Positive current results add to charge sum, negative to discharge sum
// - Master accumulation bit off freezes every sum and counter
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module bac_bank #(
   parameter int TICK_CYCLES = bac_pkg::TICK_CYCLES
) (
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        write_i,
   input  wire logic        read_i,
   output logic [31:0]      rdata_o,
   input  wire logic        curr_done_i,
   input  wire logic [15:0] curr_result_i,
   input  wire logic        int_temp_done_i,
   input  wire logic [15:0] int_temp_result_i,
   input  wire logic        ext_temp_done_i,
   input  wire logic [15:0] ext_temp_result_i,
   input  wire logic        cell2_done_i,
   input  wire logic [15:0] cell2_result_i,
   output logic             conv_master_on_o,
   output logic             sample_mode_o,
   output logic             conv_window_o,
   output logic [8:0]       nv_factory_base_o,
   output logic [8:0]       nv_gauge_base_o,
   output logic [7:0]       nv_cal_status_dflt_o
);
   logic [7:0]  conv_config_reg;
   logic [7:0]  accum_setup_reg;
   logic [31:0] charge_sum_reg;
   logic [31:0] discharge_sum_reg;
   logic [31:0] charge_time_counter_reg;
   logic [31:0] temperature_accumulator_reg;
   logic [31:0] temperature_time_counter_reg;
   logic [31:0] cell2_sum_reg;
   logic [31:0] cell2_time_count_reg;
   logic        last_sign_pos_reg;
   logic        cell2_active_reg;
   logic [7:0]  wipe;
   logic        tick;
   logic        window;
   logic        acc_all;
   logic        acc_curr;
   logic        acc_temp;
   logic        acc_cell2;
   logic [31:0] rdata_next;

   bac_event_if ev ();

   bac_tick_gen #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .clock_i       (clock_i),
      .rst_i         (rst_i),
      .master_on_i   (conv_config_reg[bac_pkg::CFG_MASTER_BIT]),
      .sample_mode_i (conv_config_reg[bac_pkg::CFG_SAMPLE_BIT]),
      .exponent_i    (conv_config_reg[bac_pkg::CFG_EXP_LSB +: bac_pkg::CFG_EXP_W]),
      .tick_o        (tick),
      .window_o      (window)
   );

   // Results only count while conversions are permitted
   bac_event_stage u_stage (
      .clock_i           (clock_i),
      .rst_i             (rst_i),
      .tick_i            (tick),
      .conv_ok_i         (conv_config_reg[bac_pkg::CFG_MASTER_BIT]),
      .curr_done_i       (curr_done_i),
      .curr_result_i     (curr_result_i),
      .int_temp_done_i   (int_temp_done_i),
      .int_temp_result_i (int_temp_result_i),
      .ext_temp_done_i   (ext_temp_done_i),
      .ext_temp_result_i (ext_temp_result_i),
      .cell2_done_i      (cell2_done_i),
      .cell2_result_i    (cell2_result_i),
      .tsel_i            (accum_setup_reg[bac_pkg::SET_TSEL_BIT]),
      .ev                (ev)
   );

   assign acc_all   = accum_setup_reg[bac_pkg::SET_MASTER_BIT];
   assign acc_curr  = acc_all && accum_setup_reg[bac_pkg::SET_CURR_BIT];
   assign acc_temp  = acc_all && accum_setup_reg[bac_pkg::SET_TEMP_BIT];
   assign acc_cell2 = acc_all && accum_setup_reg[bac_pkg::SET_CELL2_BIT];

   // Wipe strobes are write-only one-cycle pulses; wipe wins over a same-cycle update
   assign wipe = (write_i && addr_i == bac_pkg::ADDR_SUM_WIPE) ? wdata_i[7:0] : 8'h00;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         conv_config_reg <= bac_pkg::CFG_RESET;
      end else if (write_i && addr_i == bac_pkg::ADDR_CONV_CONFIG) begin
         conv_config_reg <= wdata_i[7:0] & bac_pkg::CFG_WRITE_MASK;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         accum_setup_reg <= bac_pkg::SET_RESET;
      end else if (write_i && addr_i == bac_pkg::ADDR_ACCUM_SETUP) begin
         accum_setup_reg <= wdata_i[7:0] & bac_pkg::SET_WRITE_MASK;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         last_sign_pos_reg <= 1'b0;
      end else if (ev.curr_done) begin
         last_sign_pos_reg <= ~ev.curr_result[15];
      end
   end

   // Cell-2 measurements stay "being taken" from a done event until master turns off
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cell2_active_reg <= 1'b0;
      end else if (!conv_config_reg[bac_pkg::CFG_MASTER_BIT]) begin
         cell2_active_reg <= 1'b0;
      end else if (ev.cell2_done) begin
         cell2_active_reg <= 1'b1;
      end
   end

   // Sums wrap by plain modular addition
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         charge_sum_reg    <= 32'h0;
         discharge_sum_reg <= 32'h0;
      end else begin
         if (wipe[bac_pkg::WIPE_CHARGE_SUM]) begin
            charge_sum_reg <= 32'h0;
         end else if (acc_curr && ev.curr_done && !ev.curr_result[15]) begin
            charge_sum_reg <= charge_sum_reg + {17'h0, ev.curr_result[14:0]};
         end
         if (wipe[bac_pkg::WIPE_DISCHARGE_SUM]) begin
            discharge_sum_reg <= 32'h0;
         end else if (acc_curr && ev.curr_done && ev.curr_result[15]) begin
            discharge_sum_reg <= discharge_sum_reg + {17'h0, ev.curr_result[14:0]};
         end
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         charge_time_counter_reg <= 32'h0;
      end else if (wipe[bac_pkg::WIPE_CHARGE_TIME]) begin
         charge_time_counter_reg <= 32'h0;
      end else if (ev.tick && acc_curr && last_sign_pos_reg) begin
         charge_time_counter_reg <= charge_time_counter_reg + 32'h1;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         temperature_accumulator_reg <= 32'h0;
      end else if (wipe[bac_pkg::WIPE_TEMP_SUM]) begin
         temperature_accumulator_reg <= 32'h0;
      end else if (acc_temp && ev.temp_done) begin
         temperature_accumulator_reg <= temperature_accumulator_reg + {16'h0, ev.temp_result};
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         temperature_time_counter_reg <= 32'h0;
      end else if (wipe[bac_pkg::WIPE_TEMP_TIME]) begin
         temperature_time_counter_reg <= 32'h0;
      end else if (ev.tick && acc_temp) begin
         temperature_time_counter_reg <= temperature_time_counter_reg + 32'h1;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cell2_sum_reg <= 32'h0;
      end else if (wipe[bac_pkg::WIPE_CELL2_SUM]) begin
         cell2_sum_reg <= 32'h0;
      end else if (acc_cell2 && ev.cell2_done) begin
         cell2_sum_reg <= cell2_sum_reg + {16'h0, ev.cell2_result};
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cell2_time_count_reg <= 32'h0;
      end else if (wipe[bac_pkg::WIPE_CELL2_TIME]) begin
         cell2_time_count_reg <= 32'h0;
      end else if (ev.tick && acc_cell2 && cell2_active_reg) begin
         cell2_time_count_reg <= cell2_time_count_reg + 32'h1;
      end
   end

   always_comb begin
      rdata_next = 32'h0;
      unique case (addr_i)
         bac_pkg::ADDR_CHARGE_SUM:    rdata_next = charge_sum_reg;
         bac_pkg::ADDR_DISCHARGE_SUM: rdata_next = discharge_sum_reg;
         bac_pkg::ADDR_CHARGE_TIME:   rdata_next = charge_time_counter_reg;
         bac_pkg::ADDR_TEMP_SUM:      rdata_next = temperature_accumulator_reg;
         bac_pkg::ADDR_TEMP_TIME:     rdata_next = temperature_time_counter_reg;
         bac_pkg::ADDR_CELL2_SUM:     rdata_next = cell2_sum_reg;
         bac_pkg::ADDR_CELL2_TIME:    rdata_next = cell2_time_count_reg;
         bac_pkg::ADDR_CONV_CONFIG:   rdata_next = {24'h0, conv_config_reg};
         bac_pkg::ADDR_ACCUM_SETUP:   rdata_next = {24'h0, accum_setup_reg};
         bac_pkg::ADDR_CONV_STATUS:   rdata_next = {29'h0, cell2_active_reg, last_sign_pos_reg, window};
         default:                     rdata_next = 32'h0;
      endcase
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 32'h0;
      end else if (read_i) begin
         rdata_o <= rdata_next;
      end else begin
         rdata_o <= 32'h0;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         conv_master_on_o     <= 1'b0;
         sample_mode_o        <= 1'b0;
         conv_window_o        <= 1'b0;
         nv_factory_base_o    <= 9'h0;
         nv_gauge_base_o      <= 9'h0;
         nv_cal_status_dflt_o <= 8'h0;
      end else begin
         conv_master_on_o     <= conv_config_reg[bac_pkg::CFG_MASTER_BIT];
         sample_mode_o        <= conv_config_reg[bac_pkg::CFG_SAMPLE_BIT];
         conv_window_o        <= window;
         nv_factory_base_o    <= bac_pkg::NV_FACTORY_BASE;
         nv_gauge_base_o      <= bac_pkg::NV_GAUGE_BASE;
         nv_cal_status_dflt_o <= bac_pkg::NV_CAL_STATUS_DFLT;
      end
   end
endmodule
`default_nettype wire

// ===== bench/bac_bank_properties.sv
// Port-level checks on the accumulator bank
`timescale 1ns/1ps
`default_nettype none
module bac_bank_properties (
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        write_i,
   input  wire logic        read_i,
   input  wire logic [31:0] rdata_o,
   input  wire logic        conv_master_on_o,
   input  wire logic        sample_mode_o,
   input  wire logic        conv_window_o,
   input  wire logic [8:0]  nv_factory_base_o,
   input  wire logic [8:0]  nv_gauge_base_o,
   input  wire logic [7:0]  nv_cal_status_dflt_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   logic cfg_wr;
   logic cfg_rd;
   assign cfg_wr = write_i && addr_i == bac_pkg::ADDR_CONV_CONFIG;
   assign cfg_rd = read_i && addr_i == bac_pkg::ADDR_CONV_CONFIG;
   // Window may trail the config by a stage, so the mode must settle first
   property p_master_on; cfg_wr && wdata_i[7] |-> ##[1:2] conv_master_on_o; endproperty
   a_master_on: assert property (p_master_on) else $error("master enable missed");
   property p_sample_on; cfg_wr && wdata_i[6] |-> ##[1:2] sample_mode_o; endproperty
   a_sample_on: assert property (p_sample_on) else $error("sample mode missed");
   property p_window_off; (!conv_master_on_o)[*3] |-> !conv_window_o; endproperty
   a_window_off: assert property (p_window_off) else $error("window while disabled");
   property p_run_window; (conv_master_on_o && !sample_mode_o)[*3] |-> conv_window_o; endproperty
   a_run_window: assert property (p_run_window) else $error("run mode not continuous");
   property p_sample_pulse; (sample_mode_o)[*3] ##0 conv_window_o |=> !conv_window_o; endproperty
   a_sample_pulse: assert property (p_sample_pulse) else $error("sample window too long");
   property p_cfg_rsvd; cfg_rd |=> rdata_o[5:3] == 3'h0 && rdata_o[31:8] == 24'h0; endproperty
   a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("reserved config bits set");
   property p_nv_fact; !$past(rst_i) |-> nv_factory_base_o == 9'h088; endproperty
   a_nv_fact: assert property (p_nv_fact) else $error("factory base wrong");
   property p_nv_cal; !$past(rst_i) |-> nv_cal_status_dflt_o == 8'h00; endproperty
   a_nv_cal: assert property (p_nv_cal) else $error("cal status default wrong");
   property p_nv_gauge; !$past(rst_i) |-> nv_gauge_base_o == 9'h0a5; endproperty
   a_nv_gauge: assert property (p_nv_gauge) else $error("gauge base wrong");
   c_sample: cover property (sample_mode_o && conv_window_o);
   c_cfg_rd: cover property (cfg_rd);
   c_run: cover property (conv_master_on_o && !sample_mode_o && conv_window_o);
endmodule
`default_nettype wire

// ===== bench/bac_host.sv
// Register port master standing in for the host
`timescale 1ns/1ps
`default_nettype none
module bac_host (
   input  wire logic        clock_i,
   input  wire logic [31:0] rdata_i,
   output logic [7:0]       addr_o,
   output logic [31:0]      wdata_o,
   output logic             write_o,
   output logic             read_o
);
   initial begin
      addr_o = 8'h00;
      wdata_o = 32'h0;
      write_o = 1'b0;
      read_o = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      addr_o <= a;
      wdata_o <= d;
      write_o <= 1'b1;
      @(posedge clock_i);
      write_o <= 1'b0;
   endtask
   // Data stand only in the cycle after the strobe, so sample mid-cycle
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock_i);
      addr_o <= a;
      read_o <= 1'b1;
      @(posedge clock_i);
      read_o <= 1'b0;
      @(negedge clock_i);
      d = rdata_i;
   endtask
endmodule
`default_nettype wire

// ===== bench/battery_accumulators_adc_sequencing_test.sv
// Self-checking bench for the accumulator bank
`timescale 1ns/1ps
`default_nettype none
bind bac_bank bac_bank_properties u_props (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
   .conv_master_on_o(conv_master_on_o), .sample_mode_o(sample_mode_o), .conv_window_o(conv_window_o),
   .nv_factory_base_o(nv_factory_base_o), .nv_gauge_base_o(nv_gauge_base_o),
   .nv_cal_status_dflt_o(nv_cal_status_dflt_o));
module battery_accumulators_adc_sequencing_test;
   localparam int TICK = 10;
   typedef struct packed {
      logic [7:0]  setup;
      logic [1:0]  kind;
      logic [15:0] value;
      logic [7:0]  addr;
      logic [31:0] exp_v;
   } bac_row_s;
   logic        clock_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, d, d1;
   logic        wr_s, rd_s, mst, smp, win;
   logic [3:0]  dn = 4'h0;
   logic [15:0] res [4] = '{default: 16'h0};
   logic [7:0]  tim [3] = '{8'h2c, 8'h34, 8'h3c};
   int          errors = 0;
   int          n_checks = 0;
   // Kind: 0 current, 1 internal temp, 2 external temp, 3 cell 2
   bac_row_s    rows [10] = '{
      '{8'hc0, 2'd0, 16'h0005, 8'h28, 32'h5}, '{8'hc0, 2'd0, 16'h8007, 8'h20, 32'h7},
      '{8'hc0, 2'd0, 16'h8007, 8'h28, 32'h0}, '{8'ha0, 2'd1, 16'h0123, 8'h30, 32'h123},
      '{8'ha8, 2'd2, 16'h0456, 8'h30, 32'h456}, '{8'ha8, 2'd1, 16'h0123, 8'h30, 32'h0},
      '{8'h90, 2'd3, 16'h0321, 8'h38, 32'h321}, '{8'h80, 2'd3, 16'h0321, 8'h38, 32'h0},
      '{8'h70, 2'd3, 16'h0321, 8'h38, 32'h0}, '{8'h40, 2'd0, 16'h0005, 8'h28, 32'h0}};
   always #4 clock_i = ~clock_i;
   bac_host u_host (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
      .write_o(wr_s), .read_o(rd_s));
   bac_bank #(.TICK_CYCLES(TICK)) u_dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr),
      .wdata_i(wdata), .write_i(wr_s), .read_i(rd_s), .rdata_o(rdata),
      .curr_done_i(dn[0]), .curr_result_i(res[0]), .int_temp_done_i(dn[1]), .int_temp_result_i(res[1]),
      .ext_temp_done_i(dn[2]), .ext_temp_result_i(res[2]), .cell2_done_i(dn[3]),
      .cell2_result_i(res[3]), .conv_master_on_o(mst), .sample_mode_o(smp), .conv_window_o(win),
      .nv_factory_base_o(), .nv_gauge_base_o(), .nv_cal_status_dflt_o());
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic conv(input int k, input logic [15:0] v);
      @(posedge clock_i);
      dn[k] <= 1'b1;
      res[k] <= v;
      @(posedge clock_i);
      dn <= 4'h0;
      repeat (3) @(posedge clock_i);
   endtask
   // The first pulse after a mode change may be off phase, so time the second gap
   task automatic period(input int e);
      int n;
      n = 0;
      u_host.wr(8'h43, 32'h0);
      u_host.wr(8'h43, 32'hc0 | e);
      for (int h = 0; h < 3; h++) begin
         n = 0;
         @(negedge clock_i);
         while (win !== 1'b1 && n < 4000) begin
            @(negedge clock_i);
            n++;
         end
      end
      check("window period", n + 1, (1 << e) * TICK);
   endtask
   task complete_run;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      #(30000 * 8);
      errors++;
      complete_run();
   end
   initial begin
      repeat (2) @(posedge clock_i);
      rst_i <= 1'b0;
      u_host.rd(8'h43, d);
      check("config reset", d, 32'h0);
      check("master after reset", {31'h0, mst}, 32'h0);
      u_host.wr(8'h43, 32'hffffffff);
      u_host.rd(8'h43, d);
      check("config mask", d, 32'hc7);
      u_host.wr(8'h43, 32'h80);
      foreach (rows[i]) begin
         u_host.wr(8'h63, {24'h0, rows[i].setup});
         u_host.wr(8'h62, 32'hfe);
         conv(rows[i].kind, rows[i].value);
         u_host.rd(rows[i].addr, d);
         check("row sum", d, rows[i].exp_v);
      end
      u_host.wr(8'h63, 32'hf0);
      conv(0, 16'h0002);
      conv(3, 16'h0001);
      u_host.wr(8'h62, 32'hfe);
      repeat (10 * TICK) @(posedge clock_i);
      // Tick phase against the wipe is free, so one count either way is allowed
      foreach (tim[i]) begin
         u_host.rd(tim[i], d);
         check("time count", {31'h0, d >= 9 && d <= 11}, 32'h1);
      end
      u_host.wr(8'h63, 32'h70);
      u_host.rd(8'h34, d1);
      repeat (6 * TICK) @(posedge clock_i);
      u_host.rd(8'h34, d);
      check("frozen time", d, d1);
      u_host.wr(8'h63, 32'hf0);
      conv(0, 16'h8003);
      u_host.wr(8'h62, 32'h08);
      repeat (6 * TICK) @(posedge clock_i);
      u_host.rd(8'h2c, d);
      check("charge time negative", d, 32'h0);
      // Status: cell-2 seen active, last current negative, run-mode window open
      u_host.rd(8'h64, d);
      check("status run negative", d, 32'h5);
      u_host.wr(8'h63, 32'hb0);
      u_host.wr(8'h62, 32'h50);
      conv(1, 16'h0011);
      conv(3, 16'h0022);
      u_host.wr(8'h30, 32'h1234);
      u_host.wr(8'h62, 32'h40);
      u_host.rd(8'h38, d);
      check("cell2 wiped", d, 32'h0);
      u_host.rd(8'h30, d);
      check("temp kept", d, 32'h11);
      u_host.wr(8'h62, 32'h10);
      u_host.rd(8'h30, d);
      check("temp wiped", d, 32'h0);
      u_host.rd(8'h00, d);
      check("unmapped read", d, 32'h0);
      u_host.wr(8'h43, 32'h0);
      u_host.wr(8'h63, 32'hc0);
      conv(0, 16'h0005);
      u_host.rd(8'h28, d);
      check("conversions off", d, 32'h0);
      for (int e = 0; e < 8; e++) begin
         period(e);
      end
      u_host.wr(8'h43, 32'h80);
      repeat (4) @(posedge clock_i);
      @(negedge clock_i);
      check("run window", {31'h0, win}, 32'h1);
      u_host.wr(8'h43, 32'h0);
      // Mid-run reset must clear sums that still hold data
      u_host.rd(8'h20, d1);
      check("discharge before reset", d1, 32'h3);
      @(posedge clock_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      rst_i <= 1'b0;
      u_host.rd(8'h20, d);
      check("discharge after reset", d, 32'h0);
      u_host.rd(8'h63, d);
      check("setup after reset", d, 32'h0);
      complete_run();
   end
endmodule
`default_nettype wire
